//--- eisc_consts.svh
`ifndef EISC_CONSTS_SVH
`define EISC_CONSTS_SVH
// register byte offsets
`define EISC_OFF_NMI_CTRL 12'h000
`define EISC_OFF_EXT_SENSE 12'h004
`define EISC_OFF_PRIO 12'h008
`define EISC_OFF_STATUS 12'h00C
`define EISC_OFF_CLEAR 12'h010
`define EISC_OFF_ENABLE 12'h014
// field positions
`define EISC_NMI_LEVEL_BIT 15
`define EISC_NMI_EDGE_BIT 8
`define EISC_NMI_EVT_BIT 8
`define EISC_NMI_SRC 4'h8
// reset values
`define EISC_NMI_EDGE_RST 1'b0
`define EISC_SENSE_RST 16'h0000
`define EISC_PRIO_RST 32'h0000_0000
`define EISC_EVT_RST 9'h000
`endif

//--- eisc_cpu_model.sv
`timescale 1ns/1ps
module eisc_cpu_model
  import eisc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  input wire logic req_valid,
  input wire logic [3:0] req_src,
  output logic [3:0] seen_src_r
);
  // core takes the winner while the line is raised; holds it until the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_src_r <= 4'h0;
    end else if (irq && req_valid) begin
      seen_src_r <= req_src;
    end
  end
endmodule : eisc_cpu_model

//--- eisc_ext_irq_sense.sv
`timescale 1ns/1ps
`include "eisc_consts.svh"
// Operation
// - rank pending sources, sixteen priority levels
// - one nmi input, eight external inputs; all nine maskable
// - 16-bit nmi control with edge, level
// - bit 15 shows nmi pin, read-only
// - bit 8: 0 falling, 1 rising edge
// - reserved nmi control bits read zero
// - 16-bit sense register, fields reset zero
// - input n field at bits 2n+1:2n
// - mode 00 detects low level
// - mode 01 detects falling edge
// - other modes: rising, or both edges
// - inputs one, zero at bits 3:0
module eisc_ext_irq_sense
  import eisc_pkg::*;
#(
  parameter int NEXT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_i,
  input wire logic [NEXT-1:0] ext_request_inputs,
  output logic irq_o,
  output logic req_valid_o,
  output logic req_nmi_o,
  output logic [3:0] req_src_o,
  output logic [3:0] req_level_o
);
  localparam int NSRC = NEXT + 1;

  logic nmi_s1_r, nmi_s2_r, nmi_prev_r;
  logic [NEXT-1:0] ext_s1_r, ext_s2_r, ext_prev_r;
  logic nmi_edge_select_r;
  logic [15:0] ext_sense_r;
  logic [31:0] prio_r;
  logic [NSRC-1:0] st_r, st_nxt, en_r, evt;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  logic req_valid_r, req_nmi_r;
  logic [3:0] req_src_r, req_level_r;

  // two-stage synchronisers, then one more stage as the previous sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      nmi_prev_r <= 1'b1;
      ext_s1_r <= '1;
      ext_s2_r <= '1;
      ext_prev_r <= '1;
    end else begin
      nmi_s1_r <= nmi_i;
      nmi_s2_r <= nmi_s1_r;
      nmi_prev_r <= nmi_s2_r;
      ext_s1_r <= ext_request_inputs;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // apb decode; one wait state so read data comes from a flop
  wire acc = psel & penable;
  wire first = acc & ~pready_r;
  wire wr_do = acc & pready_r & pwrite;
  wire sel_nmi = paddr == `EISC_OFF_NMI_CTRL;
  wire sel_sense = paddr == `EISC_OFF_EXT_SENSE;
  wire sel_prio = paddr == `EISC_OFF_PRIO;
  wire sel_st = paddr == `EISC_OFF_STATUS;
  wire sel_clr = paddr == `EISC_OFF_CLEAR;
  wire sel_en = paddr == `EISC_OFF_ENABLE;
  wire mapped = sel_nmi | sel_sense | sel_prio | sel_st | sel_clr | sel_en;
  wire [NSRC-1:0] clr = (wr_do & sel_clr) ? pwdata[NSRC-1:0] : '0;

  // reserved nmi control bits always zero; pin level live
  wire [15:0] nmi_ctrl_rd = {nmi_s2_r, 6'h00, nmi_edge_select_r, 8'h00};

  wire [31:0] rd_mux =
    sel_nmi ? {16'h0000, nmi_ctrl_rd} :
    sel_sense ? {16'h0000, ext_sense_r} :
    sel_prio ? prio_r :
    sel_st ? {{(32-NSRC){1'b0}}, st_r} :
    sel_en ? {{(32-NSRC){1'b0}}, en_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= first;
      pslverr_r <= first & ~mapped;
      prdata_r <= (first & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // configuration registers; bit 15 and reserved bits ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_edge_select_r <= `EISC_NMI_EDGE_RST;
      ext_sense_r <= `EISC_SENSE_RST;
      prio_r <= `EISC_PRIO_RST;
      en_r <= `EISC_EVT_RST;
    end else begin
      if (wr_do & sel_nmi) nmi_edge_select_r <= pwdata[`EISC_NMI_EDGE_BIT];
      if (wr_do & sel_sense) ext_sense_r <= pwdata[15:0];
      if (wr_do & sel_prio) prio_r <= pwdata;
      if (wr_do & sel_en) en_r <= pwdata[NSRC-1:0];
    end
  end

  // nmi edge detect: polarity chosen by edge select
  assign evt[`EISC_NMI_EVT_BIT] = nmi_edge_select_r ? (nmi_s2_r & ~nmi_prev_r) :
                                                    (~nmi_s2_r & nmi_prev_r);

  // per-input sense decode from field 2n+1:2n
  genvar g;
  generate
    for (g = 0; g < NEXT; g++) begin : g_ext
      eisc_mode_t mode;
      wire s = ext_s2_r[g];
      wire p = ext_prev_r[g];
      assign mode = eisc_mode_t'(ext_sense_r[2*g+1 -: 2]);
      assign evt[g] = (mode == EISC_LOW) ? ~s :
                      (mode == EISC_FALL) ? (p & ~s) :
                      (mode == EISC_RISE) ? (~p & s) :
                      (p ^ s);

      // checks read the second sync stage and the previous sample, never the first
      property p_low;
        @(posedge pclk) disable iff (!presetn)
          (ext_sense_r[2*g+1 -: 2] == 2'b00 && !ext_s2_r[g]) |=> st_r[g];
      endproperty
      a_low: assert property (p_low) else $error("low level not flagged");

      property p_fall;
        @(posedge pclk) disable iff (!presetn)
          (ext_sense_r[2*g+1 -: 2] == 2'b01 && ext_prev_r[g] && !ext_s2_r[g]) |=> st_r[g];
      endproperty
      a_fall: assert property (p_fall) else $error("falling edge not flagged");

      property p_rise_only;
        @(posedge pclk) disable iff (!presetn)
          (ext_sense_r[2*g+1 -: 2] == 2'b10 && !st_r[g] && !ext_s2_r[g]) |=> !st_r[g];
      endproperty
      a_rise_only: assert property (p_rise_only) else $error("rise mode set without rise");

      property p_both;
        @(posedge pclk) disable iff (!presetn)
          (ext_sense_r[2*g+1 -: 2] == 2'b11 && (ext_prev_r[g] != ext_s2_r[g])) |=> st_r[g];
      endproperty
      a_both: assert property (p_both) else $error("edge not flagged in both-edge mode");

      // a clear with no competing event must empty the flag
      property p_clear;
        @(posedge pclk) disable iff (!presetn)
          (clr[g] && !evt[g]) |=> !st_r[g];
      endproperty
      a_clear: assert property (p_clear) else $error("status not cleared");
    end
  endgenerate

  // sticky status: a new event beats a same-cycle clear
  assign st_nxt = (st_r & ~clr) | evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= `EISC_EVT_RST;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irq_r <= |(st_nxt & en_r);
    end
  end

  // prioritiser: nmi above all; then highest of 16 levels, lowest index on tie
  logic win_v, win_nmi;
  logic [3:0] win_src, win_lvl;
  wire [NSRC-1:0] pend = st_nxt & en_r;
  always_comb begin
    win_v = 1'b0;
    win_nmi = 1'b0;
    win_src = 4'h0;
    win_lvl = 4'h0;
    for (int i = 0; i < NEXT; i++) begin
      if (pend[i] && (!win_v || prio_r[4*i +: 4] > win_lvl)) begin
        win_v = 1'b1;
        win_src = 4'(i);
        win_lvl = prio_r[4*i +: 4];
      end
    end
    if (pend[`EISC_NMI_EVT_BIT]) begin
      win_v = 1'b1;
      win_nmi = 1'b1;
      win_src = `EISC_NMI_SRC;
      win_lvl = 4'hF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid_r <= 1'b0;
      req_nmi_r <= 1'b0;
      req_src_r <= 4'h0;
      req_level_r <= 4'h0;
    end else begin
      req_valid_r <= win_v;
      req_nmi_r <= win_nmi;
      req_src_r <= win_src;
      req_level_r <= win_lvl;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_o = irq_r;
  assign req_valid_o = req_valid_r;
  assign req_nmi_o = req_nmi_r;
  assign req_src_o = req_src_r;
  assign req_level_o = req_level_r;

  // checks
  property p_nmi_read;
    @(posedge pclk) disable iff (!presetn)
      (first && !pwrite && sel_nmi) |=> (prdata_r[15] == $past(nmi_s2_r)
        && prdata_r[14:9] == 6'h00 && prdata_r[7:0] == 8'h00 && prdata_r[31:16] == 16'h0000);
  endproperty
  a_nmi_read: assert property (p_nmi_read) else $error("nmi control read wrong");

  property p_nmi_edge;
    @(posedge pclk) disable iff (!presetn)
      ((nmi_edge_select_r ? (nmi_s2_r && !nmi_prev_r) : (!nmi_s2_r && nmi_prev_r))
        ##0 !clr[8]) |=> st_r[8];
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge missed");

  property p_nmi_wrong_edge;
    @(posedge pclk) disable iff (!presetn)
      (!st_r[8] && (nmi_s2_r == nmi_prev_r)) |=> !st_r[8];
  endproperty
  a_nmi_wrong_edge: assert property (p_nmi_wrong_edge) else $error("nmi set without edge");

  property p_sense_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_do && sel_sense) |=> ext_sense_r == $past(pwdata[15:0]);
  endproperty
  a_sense_wr: assert property (p_sense_wr) else $error("sense write lost");

  // sense fields move only on a write to their own offset
  property p_sense_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_do && sel_sense) |=> $stable(ext_sense_r);
  endproperty
  a_sense_hold: assert property (p_sense_hold) else $error("sense changed without write");

  // edge select takes bit 8 only; bit 15 and reserved bits are dropped
  property p_edge_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_do && sel_nmi) |=> nmi_edge_select_r == $past(pwdata[`EISC_NMI_EDGE_BIT]);
  endproperty
  a_edge_wr: assert property (p_edge_wr) else $error("edge select write lost");

  // unmapped offsets answer an error and read zero
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (first && !mapped) |=> (pslverr_r && prdata_r == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered wrong");

  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      ##3 ext_prev_r == $past(ext_request_inputs, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");

  property p_prio;
    @(posedge pclk) disable iff (!presetn)
      (req_valid_r && !req_nmi_r) |-> 4'($past(prio_r) >> (4 * req_src_r)) == req_level_r;
  endproperty
  a_prio: assert property (p_prio) else $error("winner level mismatch");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      // the line was computed with the enable that stood before the edge
      (irq_r == |(st_r & $past(en_r))) && (req_valid_r == irq_r);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      first |=> pready_r ##1 !pready_r;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  c_nmi: cover property (@(posedge pclk) disable iff (!presetn) req_nmi_r);
  c_both: cover property (@(posedge pclk) disable iff (!presetn)
    ext_sense_r[15:14] == 2'b11 && st_r[7]);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pready_r && pslverr_r);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_r));
endmodule : eisc_ext_irq_sense

//--- eisc_pkg.sv
package eisc_pkg;
  // sense encodings follow declaration order: 00 low, 01 fall, 10 rise, 11 both
  typedef enum logic [1:0] {
    EISC_LOW,
    EISC_FALL,
    EISC_RISE,
    EISC_BOTH
  } eisc_mode_t;
endpackage : eisc_pkg

//--- tb_top.sv
`timescale 1ns/1ps
`include "eisc_consts.svh"
module tb_top;
  import eisc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic nmi_i = 1'b1, pready, pslverr, irq_o, req_valid_o, req_nmi_o, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [7:0] ext = 8'hFF;
  logic [3:0] req_src_o, req_level_o, cpu_src;
  int fail_count = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  eisc_ext_irq_sense #(.NEXT(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmi_i(nmi_i), .ext_request_inputs(ext),
    .irq_o(irq_o), .req_valid_o(req_valid_o), .req_nmi_o(req_nmi_o),
    .req_src_o(req_src_o), .req_level_o(req_level_o));
  eisc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq(irq_o),
    .req_valid(req_valid_o), .req_src(req_src_o), .seen_src_r(cpu_src));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this step
    @(posedge pclk);
    if (i >= 50) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wait6();
    repeat (6) @(posedge pclk);
  endtask : wait6
  task automatic t_reset();
    apb(1'b0, `EISC_OFF_NMI_CTRL, 32'h0000_0000);
    chk("nmi ctrl", q, 32'h0000_8000);
    chk("mapped err", {31'h0, e}, 32'h0000_0000);
    apb(1'b0, `EISC_OFF_EXT_SENSE, 32'h0000_0000);
    chk("sense", q, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
  endtask : t_reset
  // every mode on every input, falling then rising edge
  task automatic t_modes();
    apb(1'b1, `EISC_OFF_ENABLE, 32'h0000_01FF);
    for (int m = 0; m < 4; m++) begin
      for (int n = 0; n < 8; n++) begin
        apb(1'b1, `EISC_OFF_EXT_SENSE, 32'(m) << (2 * n));
        apb(1'b1, `EISC_OFF_CLEAR, 32'h0000_01FF);
        ext[n] <= 1'b0;
        wait6();
        apb(1'b0, `EISC_OFF_STATUS, 32'h0000_0000);
        chk("fall", q, 32'(m != 2) << n);
        chk("irq", {31'h0, irq_o}, 32'(m != 2));
        apb(1'b1, `EISC_OFF_CLEAR, 32'h0000_01FF);
        ext[n] <= 1'b1;
        wait6();
        apb(1'b0, `EISC_OFF_STATUS, 32'h0000_0000);
        chk("rise", q, 32'(m != 1) << n);
        if (m != 1) chk("src", {28'h0, cpu_src}, 32'(n));
      end
    end
  endtask : t_modes
  // two low-level sources, higher level wins, then masking drops the line
  task automatic t_prio();
    apb(1'b1, `EISC_OFF_EXT_SENSE, 32'h0000_0000);
    apb(1'b1, `EISC_OFF_PRIO, 32'h00F0_0100);
    ext <= 8'hDB;
    wait6();
    chk("winner", {24'h0, req_src_o, req_level_o}, 32'h0000_005F);
    chk("valid", {31'h0, req_valid_o}, 32'h0000_0001);
    apb(1'b1, `EISC_OFF_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("masked", {31'h0, irq_o}, 32'h0000_0000);
    chk("valid masked", {31'h0, req_valid_o}, 32'h0000_0000);
    ext <= 8'hFF;
    apb(1'b1, `EISC_OFF_ENABLE, 32'h0000_01FF);
    wait6();
    apb(1'b1, `EISC_OFF_CLEAR, 32'h0000_01FF);
  endtask : t_prio
  task automatic t_nmi();
    nmi_i <= 1'b0;
    wait6();
    apb(1'b0, `EISC_OFF_STATUS, 32'h0000_0000);
    chk("nmi fall", q, 32'h0000_0100);
    apb(1'b1, `EISC_OFF_NMI_CTRL, 32'h0000_8100);
    apb(1'b0, `EISC_OFF_NMI_CTRL, 32'h0000_0000);
    chk("nmi ctrl low", q, 32'h0000_0100);
    apb(1'b1, `EISC_OFF_CLEAR, 32'h0000_01FF);
    nmi_i <= 1'b1;
    wait6();
    apb(1'b0, `EISC_OFF_STATUS, 32'h0000_0000);
    chk("nmi rise", q, 32'h0000_0100);
    chk("nmi req", {23'h0, req_nmi_o, req_src_o, req_level_o}, 32'h0000_018F);
    apb(1'b0, `EISC_OFF_NMI_CTRL, 32'h0000_0000);
    chk("nmi ctrl high", q, 32'h0000_8100);
  endtask : t_nmi
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_modes();
    t_prio();
    t_nmi();
    tally_and_finish();
  end
endmodule : tb_top
